// File: design/boot_strap_mode_select.sv
// Purpose: Sense strap pins at power-up or reset release and select boot flow
// Assumes: All inputs synchronous to mclk; rst is the supply-good power event
// Notes:   Captured code only changes in the sense state
//
// Overview of operation
// - Capture three straps just after release, choose mode
// - Code sets boot flow and debug/serial mapping
// - Unconnected strap reads zero via pull-down
// - Code 100: serial load, no timeout, four-wire
// - Code 001: run with two-wire debug
// - Code 000: run with four-wire debug
// - Code 010: break means load, else run
// - Code 011 plus reset toggle starts restore
// - Restore settings: none, params, image plus params
// - Unfinished restore resumes at next power-up
// - Restore lasts about eight seconds
// - Host denied access to factory image sector
// - Internal power-on reset without external pulse
// - Strap bits 0 and 1 have no other function
`timescale 1ns/10ps

module boot_strap_mode_select #(
  parameter int BREAK_WIN_CYC = boot_strap_pkg::BREAK_WIN_CYC,
  parameter int RESTORE_CYC   = boot_strap_pkg::RESTORE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Board pins
  input  wire logic [2:0]  bootStrapPins,
  input  wire logic [2:0]  bootStrapFloat,
  input  wire logic        extResetPinN,
  input  wire logic        serialRx,
  output logic             strapBit2PinOut,
  output logic             strapBit2PinOe,
  // Nonvolatile restore marker
  input  wire logic        nvPendingIn,
  output logic             nvPendingOut,
  // Boot result
  output logic [2:0]       bootMode,
  output logic             serialLoadMode,
  output logic             runMode,
  output logic             restoreBusy,
  output logic             debugTwoWire,
  output logic             debugFourWire,
  output logic             serialPortBoot,
  // Host flash guard
  input  wire logic        hostFlashReq,
  input  wire logic        hostSectorSel,
  output logic             hostFlashGrant,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    boot_strap_pkg::boot_state_t st;
    logic [2:0]                  code;
    logic [7:0]                  porCnt;
    logic [11:0]                 brkCnt;
    logic [31:0]                 winCnt;
    logic [31:0]                 rstCnt;
    logic                        extToggle;
    logic [1:0]                  restoreSel;
    logic                        s2Val;
    logic                        s2En;
    logic                        nvPending;
    logic                        ack;
    logic [31:0]                 rdata;
  } regs_t;

  regs_t r_q;
  regs_t r_d;
  logic  [2:0] strapEff;
  logic        busy;

  function automatic logic twoWire(input logic [2:0] c);
    twoWire = (c == boot_strap_pkg::CODE_RUN_TWO_WIRE);
  endfunction

  assign strapEff = bootStrapPins & ~bootStrapFloat;
  assign busy     = (read | write) & ~r_q.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_d     = r_q;
    r_d.ack = busy;
    if (busy) begin
      r_d.rdata = 32'h0;
      case (address)
        boot_strap_pkg::OFS_STATUS: begin
          r_d.rdata[boot_strap_pkg::ST_CODE_LSB +: 3]  = r_q.code;
          r_d.rdata[boot_strap_pkg::ST_STATE_LSB +: 3] = r_q.st;
          r_d.rdata[boot_strap_pkg::ST_TWO_WIRE_BIT]   = twoWire(r_q.code);
          r_d.rdata[boot_strap_pkg::ST_BUSY_BIT]       = (r_q.st == boot_strap_pkg::ST_RESTORE);
          r_d.rdata[boot_strap_pkg::ST_PEND_BIT]       = r_q.nvPending;
        end
        boot_strap_pkg::OFS_CONTROL: begin
          r_d.rdata[boot_strap_pkg::CT_SEL_LSB +: 2]  = r_q.restoreSel;
          r_d.rdata[boot_strap_pkg::CT_S2_VAL_BIT]    = r_q.s2Val;
          r_d.rdata[boot_strap_pkg::CT_S2_EN_BIT]     = r_q.s2En;
        end
        default: r_d.rdata = 32'h0;
      endcase
    end
    if (write && r_q.ack && address == boot_strap_pkg::OFS_CONTROL && byteenable[0]) begin
      r_d.restoreSel = writedata[boot_strap_pkg::CT_SEL_LSB +: 2];
      r_d.s2Val      = writedata[boot_strap_pkg::CT_S2_VAL_BIT];
      r_d.s2En       = writedata[boot_strap_pkg::CT_S2_EN_BIT];
    end
    case (r_q.st)
      boot_strap_pkg::ST_POR: begin
        if (r_q.porCnt == 8'(boot_strap_pkg::POR_CYC - 1)) begin
          r_d.st = boot_strap_pkg::ST_SENSE;
        end else begin
          r_d.porCnt = r_q.porCnt + 8'h01;
        end
      end
      boot_strap_pkg::ST_SENSE: begin
        r_d.code   = strapEff;
        r_d.brkCnt = 12'h0;
        r_d.winCnt = 32'h0;
        r_d.rstCnt = 32'h0;
        if (nvPendingIn) begin
          r_d.st = boot_strap_pkg::ST_RESTORE;
        end else begin
          case (strapEff)
            boot_strap_pkg::CODE_LOAD_FROM_SERIAL: r_d.st = boot_strap_pkg::ST_LOAD;
            boot_strap_pkg::CODE_LOAD_OR_RUN:      r_d.st = boot_strap_pkg::ST_BREAK;
            boot_strap_pkg::CODE_RESTORE_DEFAULTS: begin
              if (r_q.extToggle && r_q.restoreSel != boot_strap_pkg::RESTORE_NONE) begin
                r_d.st = boot_strap_pkg::ST_RESTORE;
              end else begin
                r_d.st = boot_strap_pkg::ST_RUN;
              end
            end
            default: r_d.st = boot_strap_pkg::ST_RUN;
          endcase
        end
      end
      boot_strap_pkg::ST_BREAK: begin
        r_d.winCnt = r_q.winCnt + 32'h1;
        r_d.brkCnt = serialRx ? 12'h0 : r_q.brkCnt + 12'h001;
        if (!serialRx && r_q.brkCnt == 12'(boot_strap_pkg::BREAK_CYC - 1)) begin
          r_d.st = boot_strap_pkg::ST_LOAD;
        end else if (r_q.winCnt == 32'(BREAK_WIN_CYC - 1)) begin
          r_d.st = boot_strap_pkg::ST_RUN;
        end
      end
      boot_strap_pkg::ST_LOAD: r_d.st = boot_strap_pkg::ST_LOAD;
      boot_strap_pkg::ST_RESTORE: begin
        r_d.nvPending = 1'b1;
        r_d.rstCnt    = r_q.rstCnt + 32'h1;
        if (r_q.rstCnt == 32'(RESTORE_CYC - 1)) begin
          r_d.nvPending = 1'b0;
          r_d.st        = boot_strap_pkg::ST_RUN;
        end
      end
      boot_strap_pkg::ST_RUN: begin
        if (write && r_q.ack && address == boot_strap_pkg::OFS_COMMAND && byteenable[0] &&
            writedata[boot_strap_pkg::CM_RESTORE_BIT] && r_q.restoreSel != boot_strap_pkg::RESTORE_NONE) begin
          r_d.rstCnt = 32'h0;
          r_d.st     = boot_strap_pkg::ST_RESTORE;
        end
      end
      boot_strap_pkg::ST_HELD: begin
        if (extResetPinN) begin
          r_d.extToggle = 1'b1;
          r_d.st        = boot_strap_pkg::ST_SENSE;
        end
      end
      default: r_d.st = boot_strap_pkg::ST_POR;
    endcase
    if (!extResetPinN) begin
      r_d.st = boot_strap_pkg::ST_HELD;
    end
    if (r_d.st != boot_strap_pkg::ST_RUN) begin
      r_d.s2En = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q            <= '0;
      r_q.st         <= boot_strap_pkg::ST_POR;
      r_q.restoreSel <= boot_strap_pkg::CONTROL_SEL_RST;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign readdata        = r_q.rdata;
  assign waitrequest     = busy;
  assign bootMode        = r_q.code;
  assign serialLoadMode  = (r_q.st == boot_strap_pkg::ST_LOAD);
  assign runMode         = (r_q.st == boot_strap_pkg::ST_RUN);
  assign restoreBusy     = (r_q.st == boot_strap_pkg::ST_RESTORE);
  assign nvPendingOut    = r_q.nvPending;
  assign debugTwoWire    = runMode && twoWire(r_q.code);
  assign debugFourWire   = (runMode || serialLoadMode) && !twoWire(r_q.code);
  assign serialPortBoot  = serialLoadMode;
  assign strapBit2PinOut = r_q.s2Val;
  assign strapBit2PinOe  = r_q.s2En && runMode;
  assign hostFlashGrant  = hostFlashReq && !hostSectorSel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CODE_HELD: assert property (
    r_q.st != boot_strap_pkg::ST_SENSE |=> $stable(r_q.code))
    else $error("captured code changed outside sensing");

  AST_PULL_DOWN: assert property (
    r_q.st == boot_strap_pkg::ST_SENSE && bootStrapFloat == 3'h7 && extResetPinN |=> r_q.code == 3'h0)
    else $error("floating straps not read as zero");

  AST_LOAD_ENTRY: assert property (
    r_q.st == boot_strap_pkg::ST_SENSE && strapEff == boot_strap_pkg::CODE_LOAD_FROM_SERIAL
    && !nvPendingIn && extResetPinN |=> serialLoadMode && debugFourWire)
    else $error("serial load mode not entered");

  AST_LOAD_NO_TIMEOUT: assert property (
    serialLoadMode && extResetPinN |=> serialLoadMode)
    else $error("serial load mode left without reset");

  AST_TWO_WIRE: assert property (
    runMode && r_q.code == boot_strap_pkg::CODE_RUN_TWO_WIRE |-> debugTwoWire && !debugFourWire)
    else $error("two-wire debug not selected");

  AST_FOUR_WIRE: assert property (
    runMode && r_q.code == boot_strap_pkg::CODE_RUN_FOUR_WIRE |-> debugFourWire && !debugTwoWire)
    else $error("four-wire debug not selected");

  AST_BREAK_LOAD: assert property (
    r_q.st == boot_strap_pkg::ST_BREAK && !serialRx && extResetPinN
    && r_q.brkCnt == 12'(boot_strap_pkg::BREAK_CYC - 1) |=> serialLoadMode)
    else $error("break did not select serial load");

  AST_RESTORE_START: assert property (
    r_q.st == boot_strap_pkg::ST_SENSE && strapEff == boot_strap_pkg::CODE_RESTORE_DEFAULTS && r_q.extToggle
    && r_q.restoreSel != boot_strap_pkg::RESTORE_NONE && extResetPinN |=> restoreBusy ##1 nvPendingOut)
    else $error("restore not started by reset toggle");

  AST_RESUME: assert property (
    r_q.st == boot_strap_pkg::ST_SENSE && nvPendingIn && extResetPinN |=> restoreBusy)
    else $error("pending restore not resumed");

  AST_DENY: assert property (
    hostSectorSel |-> !hostFlashGrant)
    else $error("host reached protected sector");

  AST_STRAP2_QUIET: assert property (
    !runMode |-> !strapBit2PinOe)
    else $error("strap bit 2 driven outside run");

  AST_BUS_ANSWER: assert property (
    (read || write) && !r_q.ack |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not in two cycles");

  AST_HELD_ON_RESET: assert property (
    !extResetPinN |=> r_q.st == boot_strap_pkg::ST_HELD)
    else $error("reset pin low did not hold the device");

  AST_SENSE_ON_RELEASE: assert property (
    r_q.st == boot_strap_pkg::ST_HELD && extResetPinN |=> r_q.st == boot_strap_pkg::ST_SENSE)
    else $error("reset release did not sense straps");

  AST_POR_EXIT: assert property (
    r_q.st == boot_strap_pkg::ST_POR && r_q.porCnt == 8'(boot_strap_pkg::POR_CYC - 1) && extResetPinN
    |=> r_q.st == boot_strap_pkg::ST_SENSE)
    else $error("internal power-on reset did not end");

  AST_DEFAULT_RUN: assert property (
    r_q.st == boot_strap_pkg::ST_SENSE && strapEff == boot_strap_pkg::CODE_RUN_FOUR_WIRE
    && !nvPendingIn && extResetPinN |=> runMode && debugFourWire)
    else $error("default straps did not boot four-wire run");

  AST_BREAK_WINDOW: assert property (
    r_q.st == boot_strap_pkg::ST_BREAK && serialRx && extResetPinN
    && r_q.winCnt == 32'(BREAK_WIN_CYC - 1) |=> runMode)
    else $error("missing break did not select run");

  AST_RESTORE_END: assert property (
    restoreBusy && extResetPinN && r_q.rstCnt == 32'(RESTORE_CYC - 1) |=> runMode && !nvPendingOut)
    else $error("restore did not finish on time");

  AST_CMD_RESTORE: assert property (
    runMode && write && r_q.ack && address == boot_strap_pkg::OFS_COMMAND && byteenable[0]
    && writedata[boot_strap_pkg::CM_RESTORE_BIT] && r_q.restoreSel != boot_strap_pkg::RESTORE_NONE
    && extResetPinN |=> restoreBusy)
    else $error("restore command not started");

endmodule

// File: design/boot_strap_pkg.sv
// Purpose: Shared constants and types for the boot strap mode selector
// Assumes: 20 MHz mclk, Avalon-MM register slave with 32-bit data
// Notes:   Times are kept in their own units; cycle counts derive from them
package boot_strap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_MHZ          = 20;
  localparam int POR_TIME_US      = 10;
  localparam int POR_CYC          = POR_TIME_US * CLK_MHZ;
  localparam int BREAK_TIME_US    = 100;
  localparam int BREAK_CYC        = BREAK_TIME_US * CLK_MHZ;
  localparam int BREAK_WIN_MS     = 10;
  localparam int BREAK_WIN_CYC    = BREAK_WIN_MS * 1000 * CLK_MHZ;
  localparam int RESTORE_TIME_MS  = 8000;
  localparam int RESTORE_CYC      = RESTORE_TIME_MS * 1000 * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Strap codes, order {bit2, bit1, bit0}
  localparam logic [2:0] CODE_RUN_FOUR_WIRE    = 3'h0;
  localparam logic [2:0] CODE_RUN_TWO_WIRE     = 3'h1;
  localparam logic [2:0] CODE_LOAD_OR_RUN      = 3'h2;
  localparam logic [2:0] CODE_RESTORE_DEFAULTS = 3'h3;
  localparam logic [2:0] CODE_LOAD_FROM_SERIAL = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Restore settings
  localparam logic [1:0] RESTORE_NONE         = 2'h0;
  localparam logic [1:0] RESTORE_PARAMS       = 2'h1;
  localparam logic [1:0] RESTORE_IMAGE_PARAMS = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_COMMAND = 4'h8;

  // STATUS fields
  localparam int ST_CODE_LSB     = 0;
  localparam int ST_STATE_LSB    = 3;
  localparam int ST_TWO_WIRE_BIT = 6;
  localparam int ST_BUSY_BIT     = 7;
  localparam int ST_PEND_BIT     = 8;
  // CONTROL fields
  localparam int CT_SEL_LSB      = 0;
  localparam int CT_S2_VAL_BIT   = 2;
  localparam int CT_S2_EN_BIT    = 3;
  // COMMAND fields
  localparam int CM_RESTORE_BIT  = 0;

  localparam logic [1:0] CONTROL_SEL_RST = RESTORE_IMAGE_PARAMS;

  ////////////////////////////////////////////////////////////////////////////
  // Boot sequencer states
  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_SENSE   = 3'b001,
    ST_BREAK   = 3'b010,
    ST_LOAD    = 3'b011,
    ST_RUN     = 3'b100,
    ST_RESTORE = 3'b101,
    ST_HELD    = 3'b110
  } boot_state_t;

endpackage

// File: bench/board_strap_model.sv
// Purpose: Board strap resistors and external reset driver
// Assumes: Bench calls pulseReset right after a rising mclk edge
// Notes:   Reset hold time shortened by parameter
`timescale 1ns/10ps

module board_strap_model #(
  parameter int HOLD_CYC = 4
) (
  // Clock
  input  wire logic       mclk,
  // Bench controls
  input  wire logic [2:0] strapCode,
  input  wire logic [2:0] floatMask,
  input  wire logic       rxBreak,
  // Board pins
  output logic [2:0]      bootStrapPins,
  output logic [2:0]      bootStrapFloat,
  output logic            extResetPinN,
  output logic            serialRx
);
  initial extResetPinN = 1'b1;
  // Unconnected strap settles at pull-down level; strap bit 2 drive-back from the device is not modelled
  assign bootStrapPins  = strapCode & ~floatMask;
  assign bootStrapFloat = floatMask;
  // Idle line high, break holds it low
  assign serialRx       = ~rxBreak;

  ////////////////////////////////////////////////////////////////////////////
  // Reset low for the hold time, then released high
  task automatic pulseReset();
    extResetPinN <= 1'b0;
    repeat (HOLD_CYC) @(posedge mclk);
    extResetPinN <= 1'b1;
  endtask
endmodule

// File: bench/boot_strap_mode_select_tb.sv
// Purpose: Self-checking bench for the boot strap mode selector
// Assumes: Short break window and restore time parameters
// Notes:   Straps and reset pin come from the board model
`timescale 1ns/10ps

module boot_strap_mode_select_tb;
  localparam int BW = 3000;
  localparam int RC = 20;
  logic        mclk = 1'b0, rst = 1'b1, rxBreak = 1'b0, nvPendingIn = 1'b0;
  logic        hostFlashReq = 1'b0, hostSectorSel = 1'b0, read = 1'b0, write = 1'b0;
  logic [2:0]  strapCode = 3'h0, floatMask = 3'h0, bootStrapPins, bootStrapFloat, bootMode;
  logic        extResetPinN, serialRx, strapBit2PinOut, strapBit2PinOe, nvPendingOut;
  logic        serialLoadMode, runMode, restoreBusy, debugTwoWire, debugFourWire;
  logic        serialPortBoot, hostFlashGrant, waitrequest;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  int          n_errors = 0, comparisons = 0, cycles = 0;

  always #25 mclk = ~mclk;

  board_strap_model #(.HOLD_CYC(4)) uBoard (.mclk(mclk), .strapCode(strapCode), .floatMask(floatMask),
    .rxBreak(rxBreak), .bootStrapPins(bootStrapPins), .bootStrapFloat(bootStrapFloat),
    .extResetPinN(extResetPinN), .serialRx(serialRx));

  boot_strap_mode_select #(.BREAK_WIN_CYC(BW), .RESTORE_CYC(RC)) uut (.mclk(mclk), .rst(rst),
    .bootStrapPins(bootStrapPins), .bootStrapFloat(bootStrapFloat), .extResetPinN(extResetPinN),
    .serialRx(serialRx), .strapBit2PinOut(strapBit2PinOut), .strapBit2PinOe(strapBit2PinOe),
    .nvPendingIn(nvPendingIn), .nvPendingOut(nvPendingOut), .bootMode(bootMode),
    .serialLoadMode(serialLoadMode), .runMode(runMode), .restoreBusy(restoreBusy),
    .debugTwoWire(debugTwoWire), .debugFourWire(debugFourWire), .serialPortBoot(serialPortBoot),
    .hostFlashReq(hostFlashReq), .hostSectorSel(hostSectorSel), .hostFlashGrant(hostFlashGrant),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    busXfer(1'b0, a, 32'h0, r);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d, q);
  endtask

  task automatic settle();
    for (int i = 0; i < BW + 400 && runMode !== 1'b1 && serialLoadMode !== 1'b1 && restoreBusy !== 1'b1; i++)
      @(negedge mclk);
  endtask

  task automatic boot(input logic [2:0] c, input logic [2:0] f, input logic b);
    @(posedge mclk);
    strapCode <= c;
    floatMask <= f;
    rxBreak   <= b;
    uBoard.pulseReset();
    settle();
  endtask

  // Flags are {load, run, restoring, two-wire, four-wire}
  task automatic expMode(input logic [2:0] c, input logic [4:0] f);
    check({bootMode, serialLoadMode, serialPortBoot, runMode, restoreBusy, debugTwoWire, debugFourWire},
          {c, f[4], f});
  endtask

  task automatic waitRestore();
    repeat (RC - 4) @(negedge mclk);
    check({restoreBusy, nvPendingOut}, 2'b11);
    for (int i = 0; i < 40 && runMode !== 1'b1; i++) @(negedge mclk);
    check({restoreBusy, nvPendingOut, runMode}, 3'b001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    settle();
    expMode(3'h0, 5'b01001);
    rd(boot_strap_pkg::OFS_CONTROL, q);
    check(q, 32'h2);
    for (int c = 0; c < 8; c++) begin
      if (c != 3) begin
        boot(c[2:0], 3'h0, 1'b0);
        expMode(c[2:0], {c == 4, c != 4, 1'b0, c == 1, c != 1});
        rd(boot_strap_pkg::OFS_STATUS, q);
        check(q[8:0], {2'b00, c == 1, (c == 4) ? boot_strap_pkg::ST_LOAD : boot_strap_pkg::ST_RUN, c[2:0]});
      end
    end
    boot(3'h2, 3'h0, 1'b1);
    expMode(3'h2, 5'b10001);
    boot(3'h7, 3'h7, 1'b0);
    expMode(3'h0, 5'b01001);
    for (int s = 0; s < 3; s++) begin
      wr(boot_strap_pkg::OFS_CONTROL, 32'(s));
      boot(3'h3, 3'h0, 1'b0);
      expMode(3'h3, (s == 0) ? 5'b01001 : 5'b00100);
      if (s != 0) waitRestore();
    end
    @(posedge mclk);
    nvPendingIn <= 1'b1;
    boot(3'h0, 3'h0, 1'b0);
    check(restoreBusy, 1'b1);
    @(posedge mclk);
    nvPendingIn <= 1'b0;
    waitRestore();
    wr(boot_strap_pkg::OFS_CONTROL, 32'he);
    @(negedge mclk);
    check({strapBit2PinOe, strapBit2PinOut}, 2'b11);
    wr(boot_strap_pkg::OFS_COMMAND, 32'h1);
    waitRestore();
    boot(3'h4, 3'h0, 1'b0);
    check({strapBit2PinOe, serialLoadMode}, 2'b01);
    @(posedge mclk);
    strapCode <= 3'h0;
    repeat (10) @(negedge mclk);
    wr(boot_strap_pkg::OFS_STATUS, 32'h0);
    rd(boot_strap_pkg::OFS_STATUS, q);
    check(q[2:0], 3'h4);
    check(bootMode, 3'h4);
    rd(4'hc, q);
    check(q, 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      {hostFlashReq, hostSectorSel} <= k[1:0];
      @(negedge mclk);
      check(hostFlashGrant, k == 2);
    end
    finish_test();
  end
endmodule
